// ---- flash_access_security_guard.sv ----
// Behaviour
// - data-move reads always go to external data RAM, never flash
// - scratchpad select maps software accesses at 0x0000-0x01FF to scratchpad
// - instruction fetches never reach the scratchpad sector
// - flash writes need write enable; erases need erase enable too
// - inverted lock byte gives count of locked pages from page 0
// - lock-byte page locked whenever any lock-byte bit is zero
// - locked pages: debug refused, unlocked code resets, locked code allowed
// - lock page read/write: open when nothing locked, else like locked
// - firmware lock page erase resets; debug erases it only when unlocked
// - changing a programmed lock byte: debug refused, firmware resets
// - reserved area: debug refused, firmware flash access resets except the part ID code read
// - flash error reset leaves flash error flag set afterwards
// - refused debug requests dropped without reset or flash change
// - debug full erase clears everything, leaving all pages unlocked
// - scratchpad locked exactly when all other pages are locked
// - lock state sampled only at reset, later writes wait for reset
// - byte at 0x3FFE reads back the part identification code
// - firmware modify with supply monitor or its reset off resets
// - power-on reset enables supply monitor and its reset source
// - interrupts held pending while a flash operation runs
// - enabled erase via data-move write erases the whole page
`timescale 1ns/1ps
module flash_access_security_guard
  import flash_guard_pkg::*;
#(
  parameter logic [13:0] LOCK_ADDR = 14'h3bff, // last user byte
  parameter logic [7:0]  PART_ID   = 8'h5a     // arbitrary value
) (
  // clock and resets
  input  wire logic                        clock_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        por_n_i,
  // apb slave
  input  wire logic [11:0]                 paddr_i,
  input  wire logic                        psel_i,
  input  wire logic                        penable_i,
  input  wire logic                        pwrite_i,
  input  wire logic [31:0]                 pwdata_i,
  output logic      [31:0]                 prdata_o,
  output logic                             pready_o,
  output logic                             pslverr_o,
  // requesters
  input  wire flash_guard_pkg::cpu_req_t   cpu_req_i,
  input  wire flash_guard_pkg::dbg_req_t   dbg_req_i,
  output logic                             cpu_ack_o,
  output logic                             dbg_ack_o,
  output logic                             dbg_drop_o,
  output logic      [7:0]                  rdata_o,
  output logic                             rdata_valid_o,
  // flash array and data ram
  input  wire logic [7:0]                  lock_byte_i,
  input  wire logic                        flash_done_i,
  input  wire logic [7:0]                  flash_rdata_i,
  output flash_guard_pkg::flash_cmd_t      flash_cmd_o,
  output flash_guard_pkg::external_data_ram_req_t       external_data_ram_req_o,
  // system
  output logic                             flash_error_reset_o,
  output logic                             irq_hold_o
);
  import flash_guard_pkg::*;

  // ==========================================================
  // state
  // ==========================================================
  typedef enum logic [2:0] {
    ST_SAMPLE = 3'b001,
    ST_IDLE   = 3'b010,
    ST_BUSY   = 3'b100
  } st_t;

  typedef struct packed {
    st_t        state;
    logic [2:0] psc;
    logic [7:0] lock;
    logic       lock_wr;
    logic       id_rd;
    logic       cpu_ack;
    logic       dbg_ack;
    logic       dbg_drop;
    logic       flash_error_reset;
    flash_cmd_t cmd;
    flash_op_t  busy_op;
    external_data_ram_req_t  external_data_ram;
    logic [7:0] rdata;
    logic       rvalid;
    logic [31:0] prdata;
    logic       pready;
    logic       pslverr;
  } state_t;

  // survives the flash error reset; reset by power-on, and an RSR write clears ferr
  typedef struct packed {
    logic ferr;
    logic mon_en;
    logic mon_rst;
    logic por_flag;
  } persist_t;

  state_t   s_q, s_d;
  persist_t p_q, p_d;
  logic [1:0] cpu_v, dbg_v;
  logic       mon_ok, any_locked, programmed, cpu_go, dbg_go;
  logic       cpu_wr, cpu_er, lock_pg;
  logic       apb_setup, apb_write;

  // ==========================================================
  // decode helpers
  // ==========================================================
  function automatic logic is_lock_page(input logic [13:0] a);
    is_lock_page = (a[13:9] == LOCK_ADDR[13:9]);
  endfunction

  // protection of an address under a given lock byte
  function automatic logic prot(input logic [13:0] a, input logic scr,
                                input logic [7:0] lk);
    logic [7:0] n;
    n = ~lk;
    if (scr)
      prot = n >= {3'h0, LOCK_ADDR[13:9]};
    else if (is_lock_page(a))
      prot = (lk != LOCK_OPEN);
    else
      prot = {3'h0, a[13:9]} < n;
  endfunction

  function automatic logic [1:0] cpu_check(input cpu_req_t r,
      input logic [2:0] psc, input logic [7:0] lk, input logic prg,
      input logic mok);
    logic scr;
    logic wr;
    logic er;
    logic res;
    scr = (r.kind != CPU_FETCH) && psc[PSC_SS_BIT] &&
          (r.addr <= SCRATCH_END);
    wr  = (r.kind == CPU_MOVE_WRITE);
    er  = wr && psc[PSC_EE_BIT];
    res = !scr && (r.addr > LOCK_ADDR);
    cpu_check = V_ALLOW;
    if (r.kind == CPU_CODE_READ && r.addr == PART_ID_ADDR && !scr)
      cpu_check = V_ALLOW;
    else if (res)
      cpu_check = V_FLASH_ERROR_RESET;
    else if (wr && !mok)
      cpu_check = V_FLASH_ERROR_RESET;
    else if (er && !scr && is_lock_page(r.addr))
      cpu_check = V_FLASH_ERROR_RESET;
    else if (wr && !er && r.addr == LOCK_ADDR && prg)
      cpu_check = V_FLASH_ERROR_RESET;
    else if (prot(r.addr, scr, lk) && !prot(r.exec_addr, 1'b0, lk))
      cpu_check = V_FLASH_ERROR_RESET;
  endfunction

  function automatic logic [1:0] dbg_check(input dbg_req_t r,
      input logic [7:0] lk, input logic prg);
    dbg_check = V_ALLOW;
    if (r.op == DBG_FULL_ERASE)
      dbg_check = V_ALLOW;
    else if (r.addr > LOCK_ADDR)
      dbg_check = V_BLOCK;
    else if (r.op == DBG_WRITE && r.addr == LOCK_ADDR && prg)
      dbg_check = V_BLOCK;
    else if (prot(r.addr, 1'b0, lk))
      dbg_check = V_BLOCK;
  endfunction

  // ==========================================================
  // request qualification
  // ==========================================================
  assign mon_ok     = p_q.mon_en && p_q.mon_rst;
  assign any_locked = (s_q.lock != LOCK_OPEN);
  assign programmed = any_locked || s_q.lock_wr;
  // the answer cycle still shows the old request; never take it twice
  assign cpu_go     = (s_q.state == ST_IDLE) && cpu_req_i.valid &&
                      !s_q.cpu_ack;
  assign dbg_go     = (s_q.state == ST_IDLE) && !cpu_req_i.valid &&
                      dbg_req_i.valid && !s_q.dbg_drop;
  assign cpu_wr     = cpu_req_i.kind == CPU_MOVE_WRITE;
  assign cpu_er     = cpu_wr && s_q.psc[PSC_WE_BIT] && s_q.psc[PSC_EE_BIT];
  assign lock_pg    = is_lock_page(cpu_req_i.addr);
  assign cpu_v      = cpu_check(cpu_req_i, s_q.psc, s_q.lock, programmed,
                                mon_ok);
  assign dbg_v      = dbg_check(dbg_req_i, s_q.lock, programmed);
  assign apb_setup  = psel_i && !penable_i;
  assign apb_write  = psel_i && penable_i && pwrite_i && !s_q.pslverr;

  // ==========================================================
  // next state
  // ==========================================================
  always_comb begin
    s_d           = s_q;
    p_d           = p_q;
    s_d.cpu_ack   = 1'b0;
    s_d.dbg_ack   = 1'b0;
    s_d.dbg_drop  = 1'b0;
    s_d.flash_error_reset      = 1'b0;
    s_d.rvalid    = 1'b0;
    s_d.cmd       = '0; // fields read zero between commands
    s_d.external_data_ram      = '0;
    // one command pulse per operation; array holds it until done
    unique case (s_q.state)
      ST_SAMPLE: begin
        s_d.lock  = lock_byte_i;
        s_d.state = ST_IDLE;
      end
      ST_IDLE: begin
        if (cpu_go) begin
          s_d.cpu_ack = 1'b1;
          if (cpu_req_i.kind == CPU_MOVE_READ ||
              (cpu_wr && !s_q.psc[PSC_WE_BIT])) begin
            s_d.external_data_ram.valid = 1'b1;
            s_d.external_data_ram.write = cpu_wr;
            s_d.external_data_ram.addr  = cpu_req_i.addr;
            s_d.external_data_ram.wdata = cpu_req_i.wdata;
          end else if (cpu_v == V_FLASH_ERROR_RESET) begin
            s_d.flash_error_reset = 1'b1;
          end else begin
            s_d.cmd.valid   = 1'b1;
            s_d.cmd.op      = cpu_er ? FL_ERASE :
                              (cpu_wr ? FL_WRITE : FL_READ);
            s_d.cmd.scratch = (cpu_req_i.kind != CPU_FETCH) &&
                              s_q.psc[PSC_SS_BIT] &&
                              (cpu_req_i.addr <= SCRATCH_END);
            s_d.cmd.addr    = cpu_req_i.addr;
            s_d.cmd.wdata   = cpu_req_i.wdata;
            s_d.busy_op     = s_d.cmd.op;
            s_d.id_rd       = !cpu_wr &&
                              cpu_req_i.addr == PART_ID_ADDR;
            if (cpu_wr && !cpu_er && cpu_req_i.addr == LOCK_ADDR &&
                !s_d.cmd.scratch)
              s_d.lock_wr = 1'b1;
            s_d.state = ST_BUSY;
          end
        end else if (dbg_go) begin
          if (dbg_v == V_ALLOW) begin
            s_d.dbg_ack     = 1'b1;
            s_d.cmd.valid   = 1'b1;
            s_d.cmd.op      = flash_op_t'(dbg_req_i.op);
            s_d.cmd.scratch = 1'b0;
            s_d.cmd.addr    = dbg_req_i.addr;
            s_d.cmd.wdata   = dbg_req_i.wdata;
            s_d.busy_op     = s_d.cmd.op;
            s_d.id_rd       = 1'b0;
            if (dbg_req_i.op == DBG_WRITE && dbg_req_i.addr == LOCK_ADDR)
              s_d.lock_wr = 1'b1;
            s_d.state = ST_BUSY;
          end else begin
            s_d.dbg_drop = 1'b1;
          end
        end
      end
      ST_BUSY: begin
        if (flash_done_i) begin
          s_d.state = ST_IDLE;
          if (s_q.busy_op == FL_READ) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = s_q.id_rd ? PART_ID : flash_rdata_i;
          end
          if (s_q.busy_op == FL_FULL_ERASE) begin
            s_d.lock    = LOCK_OPEN;
            s_d.lock_wr = 1'b0;
          end
        end
      end
    endcase
    // register reads are prepared in the setup phase
    if (apb_setup) begin
      s_d.pslverr = 1'b0;
      unique case (paddr_i)
        PSC_OFF:  s_d.prdata = {29'h0, s_q.psc};
        RSR_OFF:  s_d.prdata = {25'h0, p_q.ferr, 4'h0, p_q.mon_rst,
                                p_q.por_flag};
        SMC_OFF:  s_d.prdata = {24'h0, p_q.mon_en, 7'h0};
        STAT_OFF: s_d.prdata = {16'h0, ~s_q.lock, 7'h0, any_locked};
        default: begin
          s_d.prdata  = 32'h0;
          s_d.pslverr = 1'b1;
        end
      endcase
    end
    // writes land at the access edge
    if (apb_write) begin
      unique case (paddr_i)
        PSC_OFF: s_d.psc = pwdata_i[2:0];
        RSR_OFF: begin
          p_d.mon_rst  = pwdata_i[RSR_MRST_BIT];
          p_d.por_flag = pwdata_i[RSR_POR_BIT];
          p_d.ferr     = 1'b0;
        end
        SMC_OFF: p_d.mon_en = pwdata_i[SMC_EN_BIT];
        default: ;
      endcase
    end
    // a flash error beats a same-cycle clear
    if (s_d.flash_error_reset)
      p_d.ferr = 1'b1;
  end

  // ==========================================================
  // registers
  // ==========================================================
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q        <= '0;
      s_q.state  <= ST_SAMPLE;
      s_q.psc    <= PSC_RESET;
      s_q.lock   <= LOCK_OPEN;
      s_q.pready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // device reset leaves these alone, so the error cause is visible later; power-on or an RSR write clears ferr
  always_ff @(posedge clock_i or negedge por_n_i) begin
    if (!por_n_i) begin
      p_q.ferr     <= 1'b0;
      p_q.mon_en   <= 1'b1;
      p_q.mon_rst  <= 1'b1;
      p_q.por_flag <= 1'b1;
    end else begin
      p_q <= p_d;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign prdata_o            = s_q.prdata;
  assign pready_o            = s_q.pready;
  assign pslverr_o           = s_q.pslverr;
  assign cpu_ack_o           = s_q.cpu_ack;
  assign dbg_ack_o           = s_q.dbg_ack;
  assign dbg_drop_o          = s_q.dbg_drop;
  assign rdata_o             = s_q.rdata;
  assign rdata_valid_o       = s_q.rvalid;
  assign flash_cmd_o         = s_q.cmd;
  assign external_data_ram_req_o          = s_q.external_data_ram;
  assign flash_error_reset_o = s_q.flash_error_reset;
  assign irq_hold_o          = s_q.state[2];

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  chk_external_data_ram_route: assert property (
    cpu_go && cpu_req_i.kind == CPU_MOVE_READ
    |=> external_data_ram_req_o.valid && !flash_cmd_o.valid)
    else $error("data-move read reached flash");

  chk_scratch_map: assert property (
    cpu_go && cpu_req_i.kind == CPU_CODE_READ && s_q.psc[PSC_SS_BIT] &&
    cpu_req_i.addr <= SCRATCH_END && cpu_v == V_ALLOW
    |=> flash_cmd_o.valid && flash_cmd_o.scratch)
    else $error("scratchpad read not mapped");

  chk_no_fetch: assert property (
    cpu_go && cpu_req_i.kind == CPU_FETCH |=> !flash_cmd_o.scratch)
    else $error("fetch from scratchpad");

  chk_write_enable: assert property (
    cpu_go && cpu_wr && !s_q.psc[PSC_WE_BIT]
    |=> !flash_cmd_o.valid && external_data_ram_req_o.valid)
    else $error("flash modified without write enable");

  chk_page_erase: assert property (
    cpu_go && cpu_er && cpu_v == V_ALLOW
    |=> flash_cmd_o.valid && flash_cmd_o.op == FL_ERASE)
    else $error("enabled write did not erase page");

  chk_lock_erase: assert property (
    cpu_go && cpu_er && lock_pg && !(s_q.psc[PSC_SS_BIT] &&
    cpu_req_i.addr <= SCRATCH_END)
    |=> flash_error_reset_o && !flash_cmd_o.valid)
    else $error("lock page erase did not reset");

  chk_monitor_off: assert property (
    cpu_go && cpu_wr && s_q.psc[PSC_WE_BIT] && !mon_ok
    |=> flash_error_reset_o && !flash_cmd_o.valid)
    else $error("modify allowed with monitor off");

  chk_debug_quiet: assert property (
    dbg_go && dbg_v == V_BLOCK
    |=> dbg_drop_o && !flash_error_reset_o && !flash_cmd_o.valid)
    else $error("refused debug request had effect");

  chk_error_flag: assert property (
    flash_error_reset_o |=> p_q.ferr)
    else $error("flash error flag not set");

  chk_lock_stable: assert property (
    s_q.state != ST_SAMPLE |=> $stable(s_q.lock) || s_q.lock == LOCK_OPEN)
    else $error("lock changed without reset");

  chk_irq_hold: assert property (
    flash_cmd_o.valid |-> irq_hold_o throughout (!flash_done_i [*1]))
    else $error("interrupts not held during operation");

  cov_flash_error_reset:       cover property (cpu_go ##1 flash_error_reset_o);
  cov_full_erase: cover property (
    dbg_go && dbg_req_i.op == DBG_FULL_ERASE ##1 flash_cmd_o.valid);
  cov_id_read:    cover property (rdata_valid_o && rdata_o == PART_ID);
  cov_drop:       cover property (dbg_drop_o);

endmodule

// ---- flash_array_model.sv ----
`timescale 1ns/1ps
module flash_array_model
  import flash_guard_pkg::*;
#(
  parameter logic [13:0] LOCK_ADDR = 14'h3bff,
  parameter logic [7:0]  ID_VAL    = 8'h5a, // arbitrary value
  parameter int          LATENCY   = 3
) (
  // clock
  input  wire logic                        clock_i,
  // command from the guard
  input  wire flash_guard_pkg::flash_cmd_t cmd_i,
  // answer and lock cell
  output logic                             done_o,
  output logic [7:0]                       rdata_o,
  output logic [7:0]                       lock_o
);
  // ==========================================================
  // cell array
  // ==========================================================
  logic [7:0]  mem [logic [14:0]];
  flash_cmd_t  cmd_q;
  int          cnt;
  logic [14:0] k;

  // erased cells read as all ones
  function automatic logic [7:0] peek(input logic [14:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction

  initial begin
    mem[{1'b0, 14'h3ffe}] = ID_VAL;
    done_o = 1'b0;
    rdata_o = 8'h00;
    lock_o = 8'hff;
    cnt = 0;
  end

  // writes only clear bits, as real cells do; data wanders when idle
  always @(posedge clock_i) begin
    done_o  <= 1'b0;
    rdata_o <= ~rdata_o; // no stale byte between answers
    if (cmd_i.valid) begin
      cmd_q <= cmd_i;
      cnt   <= LATENCY;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        k = {cmd_q.scratch, cmd_q.addr};
        done_o <= 1'b1;
        case (cmd_q.op)
          FL_READ:  rdata_o <= peek(k);
          FL_WRITE: mem[k] = peek(k) & cmd_q.wdata;
          FL_ERASE: for (int i = 0; i < 512; i++)
                      mem.delete({k[14:9], i[8:0]});
          default:  mem.delete();
        endcase
      end
    end
    lock_o <= peek({1'b0, LOCK_ADDR});
  end
endmodule

// ---- flash_guard_pkg.sv ----
package flash_guard_pkg;

  // ==========================================================
  // address map of the flash array
  // ==========================================================
  localparam int          ADDR_W       = 14;
  localparam logic [13:0] SCRATCH_END  = 14'h01ff;
  localparam logic [13:0] PART_ID_ADDR = 14'h3ffe;
  localparam logic [7:0]  LOCK_OPEN    = 8'hff;

  // ==========================================================
  // register offsets and fields
  // ==========================================================
  localparam logic [11:0] PSC_OFF      = 12'h000;
  localparam logic [11:0] RSR_OFF      = 12'h004;
  localparam logic [11:0] SMC_OFF      = 12'h008;
  localparam logic [11:0] STAT_OFF     = 12'h00c;
  localparam int          PSC_WE_BIT   = 0;
  localparam int          PSC_EE_BIT   = 1;
  localparam int          PSC_SS_BIT   = 2;
  localparam int          RSR_POR_BIT  = 0;
  localparam int          RSR_MRST_BIT = 1;
  localparam int          RSR_FERR_BIT = 6;
  localparam int          SMC_EN_BIT   = 7;
  localparam logic [2:0]  PSC_RESET    = 3'h0;

  // ==========================================================
  // request kinds and verdicts
  // ==========================================================
  typedef enum logic [1:0] {
    CPU_FETCH, CPU_CODE_READ, CPU_MOVE_READ, CPU_MOVE_WRITE
  } cpu_kind_t;

  typedef enum logic [1:0] {
    DBG_READ, DBG_WRITE, DBG_PAGE_ERASE, DBG_FULL_ERASE
  } dbg_op_t;

  typedef enum logic [1:0] {
    FL_READ, FL_WRITE, FL_ERASE, FL_FULL_ERASE
  } flash_op_t;

  localparam logic [1:0] V_BLOCK = 2'h0;
  localparam logic [1:0] V_ALLOW = 2'h1;
  localparam logic [1:0] V_FLASH_ERROR_RESET  = 2'h2;

  // ==========================================================
  // carriers
  // ==========================================================
  typedef struct packed {
    logic        valid;
    cpu_kind_t   kind;
    logic [13:0] addr;
    logic [13:0] exec_addr;
    logic [7:0]  wdata;
  } cpu_req_t;

  typedef struct packed {
    logic        valid;
    dbg_op_t     op;
    logic [13:0] addr;
    logic [7:0]  wdata;
  } dbg_req_t;

  typedef struct packed {
    logic        valid;
    flash_op_t   op;
    logic        scratch;
    logic [13:0] addr;
    logic [7:0]  wdata;
  } flash_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [13:0] addr;
    logic [7:0]  wdata;
  } external_data_ram_req_t;

endpackage

// ---- tb_flash_access_security_guard.sv ----
`timescale 1ns/1ps
module tb_flash_access_security_guard;
  import flash_guard_pkg::*;
  // ==========================================================
  // signals
  // ==========================================================
  localparam logic [13:0] LOCK = 14'h3bff;
  localparam logic [7:0]  PID  = 8'h5a; // arbitrary value
  logic        clk = 1'b0, rst_n = 1'b0, por_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, cpu_ack, dbg_ack, dbg_drop, rvalid;
  logic        done, flash_error_reset, ihold, fe, acc, drp, hold, err;
  logic [7:0]  rdat, frd, lockb, rd;
  logic [31:0] rv;
  cpu_req_t    cpu_req = '0;
  dbg_req_t    dbg_req = '0;
  flash_cmd_t  fcmd, fc;
  external_data_ram_req_t   xreq, xr;
  int          n_fail = 0, checked = 0;

  always #5 clk = ~clk;

  flash_access_security_guard #(.LOCK_ADDR(LOCK), .PART_ID(PID))
    i_flash_access_security_guard (.clock_i(clk), .rst_n_i(rst_n),
    .por_n_i(por_n), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .cpu_req_i(cpu_req),
    .dbg_req_i(dbg_req), .cpu_ack_o(cpu_ack), .dbg_ack_o(dbg_ack),
    .dbg_drop_o(dbg_drop), .rdata_o(rdat), .rdata_valid_o(rvalid),
    .lock_byte_i(lockb), .flash_done_i(done), .flash_rdata_i(frd),
    .flash_cmd_o(fcmd), .external_data_ram_req_o(xreq), .flash_error_reset_o(flash_error_reset),
    .irq_hold_o(ihold));

  flash_array_model #(.LOCK_ADDR(LOCK), .ID_VAL(PID)) i_flash_array_model (
    .clock_i(clk), .cmd_i(fcmd), .done_o(done), .rdata_o(frd),
    .lock_o(lockb));

  // ==========================================================
  // shared tasks
  // ==========================================================
  task automatic chk(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic finish_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // every request is held until the edge that samples its answer
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // flash op runs until the hold drops; read byte comes with it
  // one idle edge after it keeps back-to-back requests apart
  task automatic settle();
    rd = 8'h00;
    while (ihold !== 1'b0) begin
      @(posedge clk);
      if (rvalid === 1'b1) rd = rdat;
    end
    @(posedge clk);
  endtask

  task automatic cpu(cpu_kind_t k, logic [13:0] a, x, logic [7:0] d);
    cpu_req <= '{valid: 1'b1, kind: k, addr: a, exec_addr: x, wdata: d};
    do begin
      @(posedge clk);
    end while (cpu_ack !== 1'b1);
    fe = flash_error_reset;
    fc = fcmd;
    xr = xreq;
    hold = ihold;
    cpu_req <= '0;
    settle();
  endtask

  task automatic dbg(dbg_op_t o, logic [13:0] a);
    dbg_req <= '{valid: 1'b1, op: o, addr: a, wdata: 8'h00};
    do begin
      @(posedge clk);
    end while (dbg_ack !== 1'b1 && dbg_drop !== 1'b1);
    acc = dbg_ack;
    drp = dbg_drop;
    fe = flash_error_reset;
    fc = fcmd;
    dbg_req <= '0;
    settle();
  endtask

  // device reset, then an RSR write that clears ferr; the power-on reset stays released
  task automatic sys_reset();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    apb(1'b1, RSR_OFF, 32'h3);
  endtask

  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_route();
    apb(1'b0, RSR_OFF, 0);
    chk("rsr", 32'h3, rv);
    apb(1'b0, SMC_OFF, 0);
    chk("smc", 32'h80, rv);
    apb(1'b0, 12'h010, 0);
    chk("unmapped", 32'h1, 32'(err));
    cpu(CPU_MOVE_READ, 14'h0123, 14'h1000, 8'h00);
    chk("move rd", 32'h4, 32'({xr.valid, xr.write, fc.valid}));
    cpu(CPU_MOVE_WRITE, 14'h0123, 14'h1000, 8'h42);
    chk("we off", 32'h6, 32'({xr.valid, xr.write, fc.valid}));
    apb(1'b1, PSC_OFF, 32'h2);
    cpu(CPU_MOVE_WRITE, 14'h0123, 14'h1000, 8'h42);
    chk("ee only", 32'h0, 32'(fc.valid));
    apb(1'b1, PSC_OFF, 32'h1);
    cpu(CPU_MOVE_WRITE, 14'h0123, 14'h1000, 8'h42);
    chk("write", 32'h5, 32'({fc.valid, fc.op}));
    chk("hold", 32'h1, 32'(hold));
    cpu(CPU_CODE_READ, 14'h0123, 14'h1000, 8'h00);
    chk("readback", 32'h42, 32'(rd));
    apb(1'b1, PSC_OFF, 32'h3);
    cpu(CPU_MOVE_WRITE, 14'h0155, 14'h1000, 8'h00);
    chk("erase", 32'h6, 32'({fc.valid, fc.op}));
    cpu(CPU_CODE_READ, 14'h0123, 14'h1000, 8'h00);
    chk("erased", 32'hff, 32'(rd));
    apb(1'b1, PSC_OFF, 32'h4);
    cpu(CPU_CODE_READ, 14'h0010, 14'h1000, 8'h00);
    chk("scratch", 32'h3, 32'({fc.valid, fc.scratch}));
    cpu(CPU_FETCH, 14'h0010, 14'h0010, 8'h00);
    chk("fetch", 32'h0, 32'(fc.scratch));
    apb(1'b1, PSC_OFF, 32'h0);
    cpu(CPU_CODE_READ, 14'h3ffe, 14'h1000, 8'h00);
    chk("part id", 32'(PID), 32'({fe, rd}));
    $display("done route");
  endtask

  task automatic t_faults();
    apb(1'b1, SMC_OFF, 32'h0);
    apb(1'b1, PSC_OFF, 32'h1);
    cpu(CPU_MOVE_WRITE, 14'h0300, 14'h1000, 8'h00);
    chk("monitor off", 32'h2, 32'({fe, fc.valid}));
    apb(1'b1, SMC_OFF, 32'h80);
    sys_reset();
    cpu(CPU_CODE_READ, 14'h3d00, 14'h0000, 8'h00);
    chk("reserved", 32'h1, 32'(fe));
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    apb(1'b0, RSR_OFF, 0);
    chk("error flag", 32'h1, 32'(rv[RSR_FERR_BIT]));
    apb(1'b1, RSR_OFF, 32'h3);
    dbg(DBG_READ, 14'h3d00);
    chk("dbg reserved", 32'h2, 32'({drp, fe}));
    $display("done faults");
  endtask

  task automatic t_lock();
    apb(1'b1, PSC_OFF, 32'h1);
    cpu(CPU_MOVE_WRITE, LOCK, 14'h1000, 8'hfe);
    chk("lock wr", 32'h5, 32'({fc.valid, fc.op}));
    apb(1'b0, STAT_OFF, 0);
    chk("deferred", 32'h0, rv);
    sys_reset();
    apb(1'b0, STAT_OFF, 0);
    chk("status", 32'h101, rv);
    dbg(DBG_READ, 14'h0000);
    chk("dbg locked", 32'h1, 32'(drp));
    dbg(DBG_READ, 14'h0200);
    chk("dbg open", 32'h1, 32'(acc));
    dbg(DBG_PAGE_ERASE, 14'h0000);
    chk("dbg erase lk", 32'h1, 32'(drp));
    dbg(DBG_READ, LOCK);
    chk("dbg lock pg", 32'h1, 32'(drp));
    dbg(DBG_WRITE, LOCK);
    chk("dbg relock", 32'h1, 32'(drp));
    cpu(CPU_CODE_READ, LOCK, 14'h0100, 8'h00);
    chk("locked code", 32'h1, 32'({fe, fc.valid}));
    cpu(CPU_CODE_READ, 14'h0000, 14'h1000, 8'h00);
    chk("open code", 32'h1, 32'(fe));
    sys_reset();
    apb(1'b1, PSC_OFF, 32'h3);
    cpu(CPU_MOVE_WRITE, LOCK, 14'h0100, 8'h00);
    chk("erase lock", 32'h2, 32'({fe, fc.valid}));
    sys_reset();
    dbg(DBG_FULL_ERASE, 14'h0000);
    chk("full erase", 32'hf, 32'({acc, fc.valid, fc.op}));
    dbg(DBG_READ, 14'h0000);
    chk("unlocked", 32'h1, 32'(acc));
    dbg(DBG_PAGE_ERASE, LOCK);
    chk("dbg erase pg", 32'h6, 32'({acc, fc.op}));
    $display("done lock");
  endtask

  // ==========================================================
  // main sequence and watchdog
  // ==========================================================
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_route();
    t_faults();
    t_lock();
    finish_test();
  end

  // the tests need a few hundred cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("watchdog expired");
    finish_test();
  end
endmodule
